// ---- dv/ldcp_host_model.sv ----
/*
  Two-wire bus controller model: makes scl and releases or pulls sda.
  Assumes the bench resolves sda as open drain with a pull-up and runs clk.
*/
`timescale 1ns/1ns
`default_nettype none
module ldcp_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_rel
);
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic tick();
    repeat (8) @(posedge clk);
    #1;
  endtask
  // sda only moves while scl is low
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    tick();
    scl = 1'b1;
    tick();
    r = sda_line;
    tick();
    scl = 1'b0;
    tick();
  endtask
  // also serves as repeated start
  task automatic start();
    sda_rel = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_rel = 1'b0;
    tick();
    scl = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_rel = 1'b1;
    tick();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_led_driver_control_pins.sv ----
/*
  Self-checking bench for ldcp_top: scenarios drive pins and the bus model.
  Assumes pull-ups on sda and the attention line; HOLD_CYCLES shortened to 20.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_led_driver_control_pins;
  import ldcp_pkg::*;
  localparam int HC = 20;
  logic       clk = 1'b0, rst = 1'b1, supply_low = 1'b0, uvlo = 1'b0, trigger_pin = 1'b0, tx_mask = 1'b0;
  logic [1:0] strap = STRAP_GND;
  logic [7:0] status = 8'h00;
  logic       sda_out, sda_oe_n, att_o, att_oe_n, flash, cap, scl, sda_rel, sda_line, ok;
  logic [7:0] d0, d1;
  ldcp_regs_s ctrl;
  int         err_count = 0, n_compared = 0;
  assign sda_line = sda_rel & (sda_oe_n | sda_out);
  always #25 clk = ~clk;
  ldcp_top #(.HOLD_CYCLES(HC)) DUT (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .strap_code(strap), .supply_low(supply_low), .uvlo(uvlo),
    .hard_trigger_input(trigger_pin), .tx_mask_input(tx_mask), .status_word(status), .attention_output(att_o),
    .attention_oe_n(att_oe_n),
    .flash_activate(flash), .current_cap(cap), .ctrl(ctrl));
  ldcp_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    wt(3);
    rst = 1'b0;
    wt(8);
  endtask
  // two data bytes at r and r+1; ok only if every byte was acked
  task automatic wr2(input logic [6:0] a, input logic [7:0] r, input logic [7:0] x0, input logic [7:0] x1);
    logic k;
    host.start();
    host.wr_byte({a, 1'b0}, ok);
    host.wr_byte(r, k);
    ok &= k;
    host.wr_byte(x0, k);
    ok &= k;
    host.wr_byte(x1, k);
    ok &= k;
    host.stop();
    wt(4);
  endtask
  task automatic rd2(input logic [7:0] r);
    logic k;
    host.start();
    host.wr_byte({ADDR_BASE, 1'b0}, k);
    host.wr_byte(r, k);
    host.start();
    host.wr_byte({ADDR_BASE, 1'b1}, k);
    host.rd_byte(1'b0, d0);
    host.rd_byte(1'b1, d1);
    host.stop();
    wt(4);
  endtask
  task automatic t_reset();
    chk("attention_oe_n", 8'h01, 8'(att_oe_n));
    chk("attention_output", 8'h00, 8'(att_o));
    chk("ctrl.cmd", RST_CMD, ctrl.cmd);
    $display("reset test done");
  endtask
  task automatic t_trigger();
    wr2(ADDR_BASE, REG_CMD, 8'h01 << GATE_EN_BIT, 8'h00);
    chk("write ack", 8'h01, 8'(ok));
    chk("ctrl.cmd", 8'h01 << GATE_EN_BIT, ctrl.cmd);
    trigger_pin = 1'b1;
    wt(8);
    chk("flash gated on", 8'h01, 8'(flash));
    wr2(ADDR_BASE, REG_CMD, 8'h00, 8'h00);
    chk("flash gated off", 8'h00, 8'(flash));
    trigger_pin = 1'b0;
    $display("trigger test done");
  endtask
  task automatic t_mask();
    wr2(ADDR_BASE, REG_DIM, 8'h80, 8'h5A);
    chk("ctrl.aux", 8'h5A, ctrl.aux);
    tx_mask = 1'b1;
    wt(8);
    chk("cap with top bit", 8'h01, 8'(cap));
    wr2(ADDR_BASE, REG_DIM, 8'h7F, 8'h5A);
    chk("cap without top bit", 8'h00, 8'(cap));
    tx_mask = 1'b0;
    $display("mask test done");
  endtask
  task automatic t_attention();
    status = 8'hA5;
    wt(4);
    chk("attention set", 8'h00, 8'(att_oe_n));
    rd2(REG_AUX);
    chk("read aux", 8'h5A, d0);
    chk("read stat", 8'hA5, d1);
    chk("attention cleared", 8'h01, 8'(att_oe_n));
    $display("attention test done");
  endtask
  task automatic t_strap();
    for (int s = 1; s < 4; s++) begin
      strap = 2'(s);
      do_reset();
      wr2(ADDR_BASE | 7'(s), REG_AUX, 8'h11, 8'h00);
      chk("strap early", 8'h00, 8'(ok));
      supply_low = 1'b1;
      wt(HC / 2);
      supply_low = 1'b0;
      wr2(ADDR_BASE | 7'(s), REG_AUX, 8'h11, 8'h00);
      chk("strap short hold", 8'h00, 8'(ok));
      supply_low = 1'b1;
      wt(HC + 10);
      supply_low = 1'b0;
      wr2(ADDR_BASE | 7'(s), REG_AUX, 8'h11, 8'h00);
      chk("strap adopted", 8'h01, 8'(ok));
      wr2(ADDR_BASE, REG_AUX, 8'h11, 8'h00);
      chk("default dropped", 8'h00, 8'(ok));
    end
    strap = STRAP_GND;
    do_reset();
    chk("attention after reset", 8'h01, 8'(att_oe_n));
    $display("strap test done");
  endtask
  task automatic t_lockout();
    uvlo = 1'b1;
    wt(8);
    wr2(ADDR_BASE, REG_AUX, 8'h22, 8'h00);
    chk("ack in lockout", 8'h00, 8'(ok));
    uvlo = 1'b0;
    wt(8);
    wr2(ADDR_BASE, REG_AUX, 8'h22, 8'h00);
    chk("ack after lockout", 8'h01, 8'(ok));
    $display("lockout test done");
  endtask
  initial begin
    wt(3);
    rst = 1'b0;
    wt(8);
    t_reset();
    t_trigger();
    t_mask();
    t_attention();
    t_strap();
    t_lockout();
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire

// ---- pkg/ldcp_pkg.sv ----
/*
  Constants, types and address map for the flash LED driver control pins.
  Assumes a single 20 MHz clock and an asynchronous active-high reset.
*/
// Function
// RULE1: flash is activated by the AND of the synchronised hard trigger pin and the trigger gate enable bit.
// RULE2: the attention pin is open drain, pulled low when asserted and released otherwise, no pull-up inside.
// RULE3: the attention pin is asserted whenever the status word changes.
// RULE4: a bus read of the status register releases the attention pin.
// RULE5: the four-way strap selects target address 0110000, 0110001, 0110010 or 0110011, R/W bit last.
// RULE6: with the strap at ground the default address is used at once.
// RULE7: other strap addresses are adopted only after the supply was held at ground over 100 ms, again each power-up.
// RULE8: the transmit mask input matters only when the flash level top bit is 1.
// RULE9: an effective, high transmit mask caps LED current to the 200 mA torch level.
// RULE10: after reset the attention pin stays released until new status is recorded.
// RULE11: a write is address byte, register byte, data bytes, each acknowledged, register pointer incrementing.
// RULE12: a read sets the pointer by a write, then a repeated start with R/W high returns data from there on.
// RULE13: in a multi-byte read the controller acknowledges to continue; a final byte without acknowledge ends it.
// RULE14: no acknowledge is given while the supply is under the lockout threshold.
package ldcp_pkg;
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          HOLD_MS       = 100;
  localparam int          HOLD_CYC      = HOLD_MS * (CLK_HZ / 1000) + 1;
  localparam logic [6:0]  ADDR_BASE     = 7'h30;
  localparam logic [1:0]  STRAP_GND     = 2'h0;
  localparam logic [1:0]  STRAP_SUPPLY  = 2'h1;
  localparam logic [1:0]  STRAP_DATA    = 2'h2;
  localparam logic [1:0]  STRAP_CLOCK   = 2'h3;
  localparam logic [7:0]  REG_CMD       = 8'h00;
  localparam logic [7:0]  REG_DIM       = 8'h01;
  localparam logic [7:0]  REG_AUX       = 8'h02;
  localparam logic [7:0]  REG_STAT      = 8'h03;
  localparam logic [7:0]  RST_CMD       = 8'h00;
  localparam logic [7:0]  RST_DIM       = 8'h00;
  localparam logic [7:0]  RST_AUX       = 8'h00;
  localparam logic [7:0]  RST_STAT      = 8'h00;
  localparam int          GATE_EN_BIT   = 6;
  localparam int          FLASH_TOP_BIT = 7;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] dim;
    logic [7:0] aux;
  } ldcp_regs_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_REG   = 3'b010,
    ST_WDATA = 3'b011,
    ST_ACK   = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK  = 3'b110
  } ldcp_state_e;
endpackage

// ---- src/ldcp_top.sv ----
/*
  Control front end: two-wire target, strap address, hard trigger, attention pin, transmit mask.
  Assumes scl/sda and all pins arrive asynchronously; status_word comes from logic on clk.
*/
`timescale 1ns/1ns
`default_nettype none

module ldcp_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q     <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // per bit: follow once second and third flops agree
      q     <= (s2_ff & s3_ff) | (q & (s2_ff | s3_ff));
    end
  end
endmodule

module ldcp_top import ldcp_pkg::*; #(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n,
  input  wire logic [1:0] strap_code,
  input  wire logic       supply_low,
  input  wire logic       uvlo,
  input  wire logic       hard_trigger_input,
  input  wire logic       tx_mask_input,
  input  wire logic [7:0] status_word,
  output var  logic       attention_output,
  output var  logic       attention_oe_n,
  output var  logic       flash_activate,
  output var  logic       current_cap,
  output var  ldcp_regs_s ctrl
);
  logic [5:0]  pin_q;
  logic        scl_f, sda_f, trigger_f, tx_mask_f, sup_low_f, uvlo_f;
  logic [1:0]  strap_f;
  logic        scl_d_ff, sda_d_ff;
  logic        scl_rise, scl_fall, bus_start, bus_stop;
  ldcp_state_e state_ff, ack_to_ff;
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  shift_ff, ptr_ff, rd_word, stat_ff;
  logic        drive_ff, master_ack_ff, wr_pulse, rd_pulse;
  logic        seen_ff, adopted_ff, attention_ff, primed_ff;
  logic [31:0] hold_cnt_ff;
  logic [6:0]  own_addr;

  ldcp_sync3 #(.W(6)) u_pins (
    .clk (clk),
    .rst (rst),
    .d   ({scl_in, sda_in, hard_trigger_input, tx_mask_input, supply_low, uvlo}),
    .q   (pin_q)
  );
  ldcp_sync3 #(.W(2)) u_strap (
    .clk (clk),
    .rst (rst),
    .d   (strap_code),
    .q   (strap_f)
  );
  assign {scl_f, sda_f, trigger_f, tx_mask_f, sup_low_f, uvlo_f} = pin_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_d_ff <= 1'b0;
      sda_d_ff <= 1'b0;
    end else begin
      scl_d_ff <= scl_f;
      sda_d_ff <= sda_f;
    end
  end
  assign scl_rise  = scl_f & ~scl_d_ff;
  assign scl_fall  = ~scl_f & scl_d_ff;
  assign bus_start = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
  assign bus_stop  = scl_f & scl_d_ff & ~sda_d_ff & sda_f;

  // strapped address adoption after a long supply-low hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_ff     <= 1'b0;
      adopted_ff  <= 1'b0;
      hold_cnt_ff <= '0;
    end else begin
      if (!sup_low_f) begin
        seen_ff <= 1'b1;
      end
      if (!sup_low_f || !seen_ff) begin
        hold_cnt_ff <= '0;
      end else if (hold_cnt_ff < 32'(HOLD_CYCLES)) begin
        hold_cnt_ff <= hold_cnt_ff + 32'h1;
      end else begin
        adopted_ff <= 1'b1; // RULE7
      end
    end
  end
  assign own_addr = adopted_ff ? (ADDR_BASE | {5'h00, strap_f}) : ADDR_BASE; // RULE5 RULE6

  always_comb begin
    unique case (ptr_ff)
      REG_CMD:  rd_word = ctrl.cmd;
      REG_DIM:  rd_word = ctrl.dim;
      REG_AUX:  rd_word = ctrl.aux;
      REG_STAT: rd_word = stat_ff;
      default:  rd_word = 8'h00;
    endcase
  end

  // bus target state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff      <= ST_IDLE;
      ack_to_ff     <= ST_IDLE;
      bit_cnt_ff    <= 4'h0;
      shift_ff      <= 8'h00;
      ptr_ff        <= 8'h00;
      drive_ff      <= 1'b0;
      master_ack_ff <= 1'b0;
      wr_pulse      <= 1'b0;
      rd_pulse      <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (bus_start) begin
        state_ff   <= ST_ADDR;
        bit_cnt_ff <= 4'h0;
        drive_ff   <= 1'b0;
      end else if (bus_stop) begin
        state_ff <= ST_IDLE;
        drive_ff <= 1'b0;
      end else if (scl_rise) begin
        if (state_ff == ST_ADDR || state_ff == ST_REG || state_ff == ST_WDATA) begin
          shift_ff   <= {shift_ff[6:0], sda_f};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else if (state_ff == ST_RACK) begin
          master_ack_ff <= ~sda_f; // RULE13
        end
      end else if (scl_fall) begin
        unique case (state_ff)
          ST_IDLE: begin
            drive_ff <= 1'b0;
          end
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (bit_cnt_ff == BYTE_BITS) begin
              if (uvlo_f || (state_ff == ST_ADDR && shift_ff[7:1] != own_addr)) begin
                state_ff <= ST_IDLE; // RULE14
              end else begin
                drive_ff <= 1'b1; // RULE11
                state_ff <= ST_ACK;
                if (state_ff == ST_ADDR) begin
                  ack_to_ff <= shift_ff[0] ? ST_RDATA : ST_REG; // RULE12
                end else begin
                  ack_to_ff <= ST_WDATA;
                end
                if (state_ff == ST_REG) begin
                  ptr_ff <= shift_ff;
                end
                if (state_ff == ST_WDATA) begin
                  wr_pulse <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            state_ff   <= ack_to_ff;
            bit_cnt_ff <= 4'h0;
            drive_ff   <= 1'b0;
            if (ack_to_ff == ST_RDATA) begin
              shift_ff   <= rd_word;
              drive_ff   <= ~rd_word[7];
              bit_cnt_ff <= 4'h1;
              rd_pulse   <= 1'b1;
            end
          end
          ST_RDATA: begin
            if (bit_cnt_ff == BYTE_BITS) begin
              drive_ff <= 1'b0;
              state_ff <= ST_RACK;
            end else begin
              drive_ff   <= ~shift_ff[6];
              shift_ff   <= {shift_ff[6:0], 1'b0};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
          end
          ST_RACK: begin
            if (master_ack_ff) begin
              state_ff   <= ST_RDATA; // RULE13
              shift_ff   <= rd_word;
              drive_ff   <= ~rd_word[7];
              bit_cnt_ff <= 4'h1;
              rd_pulse   <= 1'b1;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
            drive_ff <= 1'b0;
          end
        endcase
      end
      if (wr_pulse || rd_pulse) begin
        ptr_ff <= ptr_ff + 8'h01; // RULE11 RULE12
      end
    end
  end
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_ff;

  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= '{cmd: RST_CMD, dim: RST_DIM, aux: RST_AUX};
    end else if (wr_pulse) begin
      unique case (ptr_ff)
        REG_CMD: ctrl.cmd <= shift_ff;
        REG_DIM: ctrl.dim <= shift_ff;
        REG_AUX: ctrl.aux <= shift_ff;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // status capture and attention, set wins over read clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_ff      <= RST_STAT;
      primed_ff    <= 1'b0;
      attention_ff <= 1'b0; // RULE10
    end else begin
      stat_ff   <= status_word;
      // first capture after reset is the baseline, not new status
      primed_ff <= 1'b1; // RULE10
      if (primed_ff && status_word != stat_ff) begin
        attention_ff <= 1'b1; // RULE3
      end else if (rd_pulse && ptr_ff == REG_STAT) begin
        attention_ff <= 1'b0; // RULE4
      end
    end
  end
  assign attention_output = 1'b0;
  assign attention_oe_n   = ~attention_ff; // RULE2

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_activate <= 1'b0;
      current_cap    <= 1'b0;
    end else begin
      flash_activate <= trigger_f & ctrl.cmd[GATE_EN_BIT]; // RULE1
      current_cap    <= tx_mask_f & ctrl.dim[FLASH_TOP_BIT]; // RULE8 RULE9
    end
  end

  trigger_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    flash_activate == $past(trigger_f & ctrl.cmd[GATE_EN_BIT])) else $error("flash activation mismatch");
  attn_drive_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    attention_output == 1'b0 && attention_oe_n == ~attention_ff) else $error("attention pin not open drain");
  attn_set_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    (primed_ff && status_word != stat_ff) |=> !attention_oe_n) else $error("attention missed new status");
  attn_reset_a: assert property (@(posedge clk) disable iff (rst) // RULE10
    !primed_ff |=> attention_oe_n) else $error("attention set right after reset");
  attn_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    (rd_pulse && ptr_ff == REG_STAT && status_word == stat_ff) |=> attention_oe_n) else $error("status read kept attention");
  addr_default_a: assert property (@(posedge clk) disable iff (rst) // RULE6
    !adopted_ff |-> own_addr == ADDR_BASE) else $error("strap address used too early");
  addr_adopt_a: assert property (@(posedge clk) disable iff (rst) // RULE7
    $rose(adopted_ff) |-> $past(hold_cnt_ff) == 32'(HOLD_CYCLES) && $past(sup_low_f)) else $error("address adopted early");
  mask_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    !ctrl.dim[FLASH_TOP_BIT] ##1 !ctrl.dim[FLASH_TOP_BIT] |-> !current_cap) else $error("mask acted at low level");
  mask_cap_a: assert property (@(posedge clk) disable iff (rst) // RULE9
    (tx_mask_f && ctrl.dim[FLASH_TOP_BIT]) |=> current_cap) else $error("current cap not applied");
  uvlo_ack_a: assert property (@(posedge clk) disable iff (rst) // RULE14
    (scl_fall && uvlo_f && !bus_start && !bus_stop && state_ff != ST_ACK && state_ff != ST_RDATA
     && state_ff != ST_RACK) |=> sda_oe_n) else $error("ack given under lockout");
  ptr_inc_a: assert property (@(posedge clk) disable iff (rst) // RULE11
    wr_pulse |=> ptr_ff == $past(ptr_ff) + 8'h01) else $error("pointer did not advance");
endmodule

`default_nettype wire
